// File: test/tw8_pin_load.sv
`timescale 1ns/10ps
module tw8_pin_load (
  input  wire logic pin_i,
  input  wire logic pin_oe_i,
  output logic      pad_o
);
  // an undriven pad floats up to the pull-up level
  assign pad_o = pin_oe_i ? pin_i : 1'b1;
endmodule : tw8_pin_load

// File: test/tw8_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module timer8_waveform_modes_tb_top;
  import tw8_pkg::*;
  logic       clk    = 1'b0;
  logic       rst_n  = 1'b0;
  logic       tick   = 1'b1;
  logic [2:0] addr   = 3'h0;
  logic [7:0] wdata  = 8'h00;
  logic       wr_s   = 1'b0;
  logic       rd_s   = 1'b0;
  logic       port_d = 1'b0;
  logic [7:0] rdata;
  logic [7:0] c;
  logic [7:0] d;
  logic       pin;
  logic       oe;
  logic       pad;
  logic       wave;
  int         fails    = 0;
  int         compares = 0;
  int         cyc      = 0;
  int         div      = 1;
  int         hi;
  int         per;
  tw8_timer tw8_timer_inst (
    .ref_clk_i(clk), .rst_n_i(rst_n), .timer_clock_enable_i(tick),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .port_data_i(port_d), .rdata_o(rdata), .pin_o(pin),
    .pin_oe_o(oe), .waveform_out_o(wave)
  );
  tw8_pin_load tw8_pin_load_inst (.pin_i(pin), .pin_oe_i(oe), .pad_o(pad));
  initial begin
    forever #25 clk = ~clk;
  end
  // div 2 gives a tick on every other clock, like a prescaler
  always @(posedge clk) begin
    cyc  <= cyc + 1;
    tick <= (div == 1) | ~tick;
  end
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd
  task automatic setup(input logic [1:0] m, input logic [1:0] a, input logic [7:0] v);
    wr(REG_CTRL, {3'h0, 1'b1, a, m});
    wr(REG_CMP, v);
  endtask : setup
  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (pad !== v && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      fails++;
      tally_and_finish;
    end
  endtask : wait_lvl
  // first edges may belong to the old compare value, so the fast and phase correct callers measure twice
  task automatic meas(output int h, output int p);
    int t0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    t0 = cyc;
    wait_lvl(1'b0);
    h = cyc - t0;
    wait_lvl(1'b1);
    p = cyc - t0;
  endtask : meas
  task automatic steady(input logic [1:0] m, input logic [1:0] a, input logic [7:0] v, input logic l);
    int n;
    n = 0;
    setup(m, a, v);
    // phase correct loads at top, so the level can settle only one full period later
    repeat (1100) @(posedge clk);
    repeat (300) begin
      @(negedge clk);
      n += int'(pad !== l) + int'(wave !== l);
    end
    `CHK(n, 0)
  endtask : steady
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h7a77));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(3'h6, 8'hFF);
    rd(3'h6, d);
    `CHK(d, 8'h00)
    rd(REG_CTRL, d);
    `CHK(d, 8'h00)
    for (int k = 1; k <= 2; k++) begin
      div = k;
      c = 8'($urandom_range(1, 9));
      setup(MODE_CTC, ACT_TOGGLE, c);
      wr(REG_COUNT, 8'h00);
      meas(hi, per);
      `CHK(hi, k * (c + 1))
      rd(REG_FLAGS, d);
      `CHK(d[FLG_CMP_BIT], 1'b1)
    end
    div = 1;
    setup(MODE_CTC, ACT_TOGGLE, 8'h10);
    wr(REG_COUNT, 8'hF0);
    wr(REG_FLAGS, 8'h03);
    repeat (20) @(posedge clk);
    rd(REG_FLAGS, d);
    `CHK(d, 8'h01)
    wr(REG_COUNT, 8'h00);
    wr(REG_FLAGS, 8'h03);
    wr(REG_COUNT, 8'h10);
    repeat (3) @(posedge clk);
    rd(REG_FLAGS, d);
    `CHK(d[FLG_CMP_BIT], 1'b0)
    $display("test ctc finished");
    c = 8'($urandom_range(8, 200));
    wr(REG_FLAGS, 8'h03);
    for (int a = 2; a <= 3; a++) begin
      setup(MODE_FAST, 2'(a), c);
      meas(hi, per);
      meas(hi, per);
      `CHK(per, 256)
      `CHK(hi, (a == 2) ? c + 1 : 255 - c)
    end
    rd(REG_FLAGS, d);
    `CHK(d[FLG_OVF_BIT], 1'b1)
    setup(MODE_FAST, ACT_CLEAR, 8'h00);
    meas(hi, per);
    meas(hi, per);
    `CHK(hi, 1)
    setup(MODE_FAST, ACT_TOGGLE, c);
    meas(hi, per);
    meas(hi, per);
    `CHK(hi, 256)
    steady(MODE_FAST, ACT_CLEAR, 8'hFF, 1'b1);
    $display("test fast finished");
    wr(REG_FLAGS, 8'h03);
    setup(MODE_PCPWM, ACT_CLEAR, c);
    meas(hi, per);
    meas(hi, per);
    `CHK(per, 510)
    rd(REG_FLAGS, d);
    `CHK(d[FLG_OVF_BIT], 1'b1)
    steady(MODE_PCPWM, ACT_CLEAR, 8'h00, 1'b0);
    steady(MODE_PCPWM, ACT_CLEAR, 8'hFF, 1'b1);
    steady(MODE_PCPWM, ACT_SET, 8'hFF, 1'b0);
    $display("test phase correct finished");
    setup(MODE_FAST, ACT_OFF, 8'h40);
    repeat (6) begin
      port_d <= 1'($urandom);
      repeat (3) @(posedge clk);
      `CHK(pad, port_d)
    end
    wr(REG_CTRL, {3'h0, 1'b0, ACT_CLEAR, MODE_FAST});
    repeat (3) @(posedge clk);
    `CHK(oe, 1'b0)
    $display("test pin finished");
    tally_and_finish;
  end
endmodule : timer8_waveform_modes_tb_top

// File: verilog/tw8_pkg.sv
package tw8_pkg;
  // waveform modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PCPWM  = 2'h1;
  localparam logic [1:0] MODE_CTC    = 2'h2;
  localparam logic [1:0] MODE_FAST   = 2'h3;
  // compare actions
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  // register offsets
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_COUNT  = 3'h1;
  localparam logic [2:0] REG_CMP    = 3'h2;
  localparam logic [2:0] REG_FLAGS  = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACT_LSB  = 2;
  localparam int CTRL_DIR_BIT  = 4;
  // flag field positions
  localparam int FLG_OVF_BIT = 0;
  localparam int FLG_CMP_BIT = 1;
  // counter extremes and reset values
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [2:0] RST_ADDR   = 3'h0;
endpackage : tw8_pkg

// File: verilog/tw8_timer.sv
`timescale 1ns/10ps
module tw8_timer
  import tw8_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       timer_clock_enable_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       port_data_i,
  output logic      [7:0] rdata_o,
  output logic            pin_o,
  output logic            pin_oe_o,
  output logic            waveform_out_o
);

  typedef struct packed {
    logic [1:0] waveform_mode_field;
    logic [1:0] compare_action_field;
    logic       pin_dir;
    logic [7:0] count_value;
    logic [7:0] compare_value_reg;
    logic [7:0] compare_buffer;
    logic       count_down;
    logic       block_match;
    logic       overflow_flag;
    logic       compare_match_flag;
    logic       waveform_out;
    logic       pin;
    logic       pin_oe;
    logic [7:0] rdata;
  } tw8_state_t;

  tw8_state_t st;
  tw8_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  logic       match;
  logic       ovf_set;
  logic       at_max;
  logic       at_bottom;
  logic [7:0] ctrl_rd;

  assign at_max    = (st.count_value == CNT_MAX);
  assign at_bottom = (st.count_value == CNT_BOTTOM);
  assign match     = timer_clock_enable_i && !st.block_match &&
                     (st.count_value == st.compare_value_reg);
  assign ctrl_rd   = {3'h0, st.pin_dir, st.compare_action_field, st.waveform_mode_field};
  // overflow event of this edge, so a software clear cannot swallow it
  assign ovf_set   = timer_clock_enable_i && ((st.waveform_mode_field == MODE_PCPWM) ?
                     (st.count_value == 8'h01 && st.count_down) : at_max);

  always_comb begin
    next_st       = st;
    next_st.rdata = RST_BYTE;
    if (timer_clock_enable_i) begin
      next_st.block_match = 1'b0;
    end

    // counting, all steps gated by the timer clock enable
    if (timer_clock_enable_i) begin
      case (st.waveform_mode_field)
        MODE_PCPWM: begin
          if (at_max) begin
            next_st.count_down  = 1'b1;
            next_st.count_value = st.count_value - 8'h01;
          end else if (st.count_down && at_bottom) begin
            next_st.count_down  = 1'b0;
            next_st.count_value = st.count_value + 8'h01;
          end else if (st.count_down) begin
            next_st.count_value = st.count_value - 8'h01;
          end else begin
            next_st.count_value = st.count_value + 8'h01;
          end
          if (st.count_value == 8'h01 && st.count_down) begin
            next_st.overflow_flag = 1'b1;
          end
          if (at_max) begin
            next_st.compare_value_reg = st.compare_buffer;
          end
        end
        MODE_CTC: begin
          if (match) begin
            next_st.count_value = CNT_BOTTOM;
          end else begin
            next_st.count_value = st.count_value + 8'h01;
          end
          if (at_max) begin
            next_st.overflow_flag = 1'b1;
          end
        end
        MODE_FAST: begin
          next_st.count_value = st.count_value + 8'h01;
          if (at_max) begin
            next_st.overflow_flag     = 1'b1;
            next_st.compare_value_reg = st.compare_buffer;
          end
        end
        default: begin
          next_st.count_value = st.count_value + 8'h01;
          if (at_max) begin
            next_st.overflow_flag = 1'b1;
          end
        end
      endcase
    end

    if (match) begin
      next_st.compare_match_flag = 1'b1;
    end

    // waveform generation
    case (st.waveform_mode_field)
      MODE_FAST: begin
        if (st.compare_action_field == ACT_TOGGLE) begin
          if (match) begin
            next_st.waveform_out = !st.waveform_out;
          end
        end else if (st.compare_action_field[1]) begin
          // match at max ignored so bottom action wins: constant level
          if (timer_clock_enable_i && at_max) begin
            next_st.waveform_out = !st.compare_action_field[0];
          end else if (match) begin
            next_st.waveform_out = st.compare_action_field[0];
          end
        end
      end
      MODE_PCPWM: begin
        if (st.compare_action_field[1] && timer_clock_enable_i) begin
          if (at_max && st.compare_value_reg != CNT_MAX) begin
            // level at top is the up-match result, restores symmetry
            next_st.waveform_out = st.compare_action_field[0];
          end else if (at_max) begin
            next_st.waveform_out = !st.compare_action_field[0];
          end else if (match) begin
            // at bottom the turn is pending, so a match there counts as up-counting
            next_st.waveform_out = (st.count_down && !at_bottom) ? !st.compare_action_field[0]
                                                 : st.compare_action_field[0];
          end
        end
      end
      default: begin
        if (match) begin
          case (st.compare_action_field)
            ACT_TOGGLE: next_st.waveform_out = !st.waveform_out;
            ACT_CLEAR:  next_st.waveform_out = 1'b0;
            ACT_SET:    next_st.waveform_out = 1'b1;
            default:    next_st.waveform_out = st.waveform_out;
          endcase
        end
      end
    endcase

    // register port
    if (wr_i) begin
      case (addr_i)
        REG_CTRL: begin
          next_st.waveform_mode_field  = wdata_i[CTRL_MODE_LSB +: 2];
          next_st.compare_action_field = wdata_i[CTRL_ACT_LSB +: 2];
          next_st.pin_dir              = wdata_i[CTRL_DIR_BIT];
        end
        REG_COUNT: begin
          next_st.count_value = wdata_i;
          next_st.block_match = 1'b1;
        end
        REG_CMP: begin
          next_st.compare_buffer = wdata_i;
          if (!st.waveform_mode_field[0]) begin
            next_st.compare_value_reg = wdata_i;
          end
        end
        REG_FLAGS: begin
          // write one clears; a same-cycle event keeps the flag
          if (wdata_i[FLG_OVF_BIT] && !ovf_set) begin
            next_st.overflow_flag = 1'b0;
          end
          if (wdata_i[FLG_CMP_BIT] && !match) begin
            next_st.compare_match_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        REG_CTRL:   next_st.rdata = ctrl_rd;
        REG_COUNT:  next_st.rdata = st.count_value;
        REG_CMP:    next_st.rdata = st.compare_buffer;
        REG_FLAGS:  next_st.rdata = {6'h00, st.compare_match_flag, st.overflow_flag};
        REG_STATUS: next_st.rdata = {6'h00, st.count_down, st.waveform_out};
        default:    next_st.rdata = RST_BYTE;
      endcase
    end

    // pin mux: disconnected action leaves the port value
    next_st.pin_oe = st.pin_dir;
    next_st.pin    = (st.compare_action_field == ACT_OFF) ? port_data_i : st.waveform_out;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o        = st.rdata;
  assign pin_o          = st.pin;
  assign pin_oe_o       = st.pin_oe;
  assign waveform_out_o = st.waveform_out;

  ////////////////////////////////////////////////////////////////////////////
  ctc_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (match && st.waveform_mode_field == MODE_CTC) |=> st.compare_match_flag)
    else $error("compare flag not set on match");
  ctc_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (match && st.waveform_mode_field == MODE_CTC && !wr_i) |=> st.count_value == CNT_BOTTOM)
    else $error("count not cleared after match");
  ctc_toggle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (match && st.waveform_mode_field == MODE_CTC && st.compare_action_field == ACT_TOGGLE)
    |=> st.waveform_out != $past(st.waveform_out))
    else $error("toggle missed");
  pin_dir_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    pin_oe_o == $past(st.pin_dir))
    else $error("pin enable wrong");
  fast_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && at_max && st.waveform_mode_field == MODE_FAST && !wr_i)
    |=> st.count_value == CNT_BOTTOM && st.overflow_flag)
    else $error("fast wrap wrong");
  pc_turn_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && at_max && st.waveform_mode_field == MODE_PCPWM && !wr_i)
    |=> st.count_down && st.count_value == 8'hFE)
    else $error("phase correct turn wrong");
  pc_ovf_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st.waveform_mode_field == MODE_PCPWM && $rose(at_bottom) && st.count_down)
    |-> st.overflow_flag)
    else $error("overflow not set at bottom");
  write_block_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == REG_COUNT) |=> !match)
    else $error("match after count write");
  rd_data_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == REG_COUNT && !wr_i) |=> rdata_o == $past(st.count_value))
    else $error("read data wrong");
  rd_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == RST_BYTE)
    else $error("read data not idle");
  rd_ctrl_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == REG_CTRL) |=> rdata_o == $past(ctrl_rd))
    else $error("control read wrong");

  // clear-on-compare counting and flags, flag keeping on clear and count hold without tick
  ctc_count_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && !match && st.waveform_mode_field == MODE_CTC && !(wr_i && addr_i == REG_COUNT))
    |=> st.count_value == 8'($past(st.count_value) + 8'h01))
    else $error("clear-on-compare count step wrong");
  ctc_ovf_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && at_max && st.waveform_mode_field == MODE_CTC) |=> st.overflow_flag)
    else $error("overflow not set at wrap");
  ctc_direct_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == REG_CMP && st.waveform_mode_field == MODE_CTC)
    |=> st.compare_value_reg == $past(wdata_i))
    else $error("compare write not immediate");
  cmp_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (match && wr_i && addr_i == REG_FLAGS) |=> st.compare_match_flag)
    else $error("compare flag lost to clear");
  ovf_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (ovf_set && wr_i && addr_i == REG_FLAGS) |=> st.overflow_flag)
    else $error("overflow flag lost to clear");
  count_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!timer_clock_enable_i && !(wr_i && addr_i == REG_COUNT)) |=> $stable(st.count_value))
    else $error("count moved without tick");

  // fast pwm
  fast_count_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && st.waveform_mode_field == MODE_FAST && !(wr_i && addr_i == REG_COUNT))
    |=> st.count_value == 8'($past(st.count_value) + 8'h01))
    else $error("fast count step wrong");
  fast_ovf_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && at_max && st.waveform_mode_field == MODE_FAST) |=> st.overflow_flag)
    else $error("fast overflow missing");
  fast_bottom_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && at_max && st.waveform_mode_field == MODE_FAST && st.compare_action_field[1])
    |=> st.waveform_out == !$past(st.compare_action_field[0]))
    else $error("fast bottom level wrong");
  fast_match_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (match && !at_max && st.waveform_mode_field == MODE_FAST && st.compare_action_field[1])
    |=> st.waveform_out == $past(st.compare_action_field[0]))
    else $error("fast match level wrong");
  fast_toggle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (match && st.waveform_mode_field == MODE_FAST && st.compare_action_field == ACT_TOGGLE)
    |=> st.waveform_out != $past(st.waveform_out))
    else $error("fast toggle missed");
  fast_buffer_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && at_max && st.waveform_mode_field == MODE_FAST)
    |=> st.compare_value_reg == $past(st.compare_buffer))
    else $error("fast compare not loaded");
  fast_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st.waveform_mode_field == MODE_FAST && !(timer_clock_enable_i && at_max))
    |=> $stable(st.compare_value_reg))
    else $error("fast compare changed early");

  // phase correct pwm
  pc_up_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && !st.count_down && !at_max && st.waveform_mode_field == MODE_PCPWM &&
     !(wr_i && addr_i == REG_COUNT))
    |=> st.count_value == 8'($past(st.count_value) + 8'h01))
    else $error("phase correct up step wrong");
  pc_down_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && st.count_down && !at_bottom && st.waveform_mode_field == MODE_PCPWM &&
     !(wr_i && addr_i == REG_COUNT))
    |=> st.count_value == 8'($past(st.count_value) - 8'h01))
    else $error("phase correct down step wrong");
  pc_rise_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && st.count_down && at_bottom && st.waveform_mode_field == MODE_PCPWM &&
     !(wr_i && addr_i == REG_COUNT))
    |=> !st.count_down && st.count_value == 8'h01)
    else $error("phase correct bottom turn wrong");
  pc_ovf_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && st.count_down && st.count_value == 8'h01 && st.waveform_mode_field == MODE_PCPWM)
    |=> st.overflow_flag)
    else $error("phase correct overflow missing");
  pc_upmatch_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (match && !st.count_down && !at_max && st.waveform_mode_field == MODE_PCPWM && st.compare_action_field[1])
    |=> st.waveform_out == $past(st.compare_action_field[0]))
    else $error("up match level wrong");
  pc_dnmatch_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (match && st.count_down && !at_bottom && !at_max && st.waveform_mode_field == MODE_PCPWM &&
     st.compare_action_field[1])
    |=> st.waveform_out == !$past(st.compare_action_field[0]))
    else $error("down match level wrong");
  pc_bottom_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (match && at_bottom && st.waveform_mode_field == MODE_PCPWM && st.compare_action_field[1])
    |=> st.waveform_out == $past(st.compare_action_field[0]))
    else $error("bottom compare level wrong");
  pc_top_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && at_max && st.compare_value_reg != CNT_MAX &&
     st.waveform_mode_field == MODE_PCPWM && st.compare_action_field[1])
    |=> st.waveform_out == $past(st.compare_action_field[0]))
    else $error("top level not up-match level");
  pc_buffer_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_clock_enable_i && at_max && st.waveform_mode_field == MODE_PCPWM)
    |=> st.compare_value_reg == $past(st.compare_buffer))
    else $error("phase correct compare not loaded");

  // pin mux
  pin_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st.compare_action_field == ACT_OFF) |=> pin_o == $past(port_data_i))
    else $error("port value not on pin");
  pin_wave_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st.compare_action_field != ACT_OFF) |=> pin_o == $past(st.waveform_out))
    else $error("waveform not on pin");

  ctc_match_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    match && st.waveform_mode_field == MODE_CTC);
  fast_wrap_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    timer_clock_enable_i && at_max && st.waveform_mode_field == MODE_FAST);
  pc_turn_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    timer_clock_enable_i && at_max && st.waveform_mode_field == MODE_PCPWM);
  pc_ovf_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ovf_set && st.waveform_mode_field == MODE_PCPWM);
  flag_clear_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == REG_FLAGS && st.overflow_flag);

endmodule : tw8_timer
